// ---- design/spi_cmd_regs.svh ----
// constants for the serial flash command front end
// assumes inclusion by bare name from both ends
`ifndef SPI_CMD_REGS_SVH
`define SPI_CMD_REGS_SVH

// =====================================================================
// opcodes
`define OP_RD_FAST      8'h0B
`define OP_RD_SLOW      8'h03
`define OP_ERASE_4K     8'h20
`define OP_ERASE_32K    8'h52
`define OP_ERASE_64K    8'hD8
`define OP_CHIP_ERASE_A 8'h60
`define OP_CHIP_ERASE_B 8'hC7
`define OP_PROGRAM      8'h02
`define OP_WR_EN        8'h06
`define OP_WR_DIS       8'h04
`define OP_PROT         8'h36
`define OP_UNPROT       8'h39
`define OP_RD_PROT      8'h3C
`define OP_RD_STATUS    8'h05
`define OP_WR_STATUS    8'h01
`define OP_RD_ID        8'h9F
`define OP_PWR_DOWN     8'hB9
`define OP_PWR_RESUME   8'hAB

// =====================================================================
// framing
`define LAST_BIT        3'h7
`define LAST_ADDR_BYTE  2'h2
`define PAGE_BYTES      9'h100

// =====================================================================
// timing
`define CLK_PERIOD_NS      50
`define HOST_SCK_PERIOD_NS 800
`define SCK_HALF_CYCLES    (`HOST_SCK_PERIOD_NS / (2 * `CLK_PERIOD_NS))

`endif

// ---- design/spi_cmd_pkg.sv ----
// types shared by both ends of the serial flash command link
// assumes the constants header sits in the include path
package spi_cmd_pkg;
  // =====================================================================
  // command shape
  typedef enum logic [1:0] {DIR_NONE = 2'h0, DIR_IN = 2'h1, DIR_OUT = 2'h2} dir_t;
  typedef struct packed {
    logic known;
    logic has_addr;
    logic has_dummy;
    logic one_byte;
    dir_t dir;
  } cmd_info_t;

  // =====================================================================
  // state machines, codes gray in the order listed
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0, ST_OPC = 3'h1, ST_ADDR = 3'h3, ST_DUMMY = 3'h2,
    ST_DIN = 3'h6, ST_DOUT = 3'h7, ST_IGNR = 3'h5, ST_HOLD = 3'h4
  } dev_state_t;
  typedef enum logic [2:0] {
    H_IDLE = 3'h0, H_SEL = 3'h1, H_LOW = 3'h3, H_HIGH = 3'h2,
    H_WAIT = 3'h6, H_END = 3'h7, H_DESEL = 3'h5
  } host_state_t;
endpackage

// ---- design/spi_link_if.sv ----
// four-wire serial link between flash front end and its host
// assumes the bench joins both modports; data out pin is three-state
`timescale 1ns/1ps
interface spi_link_if;
  logic cs_n;
  logic sck;
  logic mosi;
  logic miso;
  logic miso_oe;
  // released line reads high, as with a pull-up
  logic miso_line;
  assign miso_line = miso_oe ? miso : 1'b1;

  modport host (output cs_n, output sck, output mosi, input miso_line);
  modport device (input cs_n, input sck, input mosi, output miso, output miso_oe);
endinterface

// ---- design/fifo2.sv ----
// two-entry buffer with valid and ready on both sides
// assumes one clock domain shared with its user
`timescale 1ns/1ps
module fifo2 #(
  parameter int WIDTH = 9
) (
  // clock and reset
  input  wire logic             i_clock,
  input  wire logic             i_rst,
  // filling side
  input  wire logic             i_in_valid,
  output logic                  o_in_ready,
  input  wire logic [WIDTH-1:0] i_in_data,
  // draining side
  output logic                  o_out_valid,
  input  wire logic             i_out_ready,
  output logic [WIDTH-1:0]      o_out_data
);
  logic [WIDTH-1:0] mem [2];
  logic             wr_ptr_reg;
  logic             rd_ptr_reg;
  logic [1:0]       count_reg;
  logic [1:0]       count_next;
  logic             push;
  logic             pop;

  // =====================================================================
  // handshakes
  assign push       = i_in_valid & o_in_ready;
  assign pop        = o_out_valid & i_out_ready;
  assign count_next = count_reg + {1'b0, push} - {1'b0, pop};
  assign o_out_data = mem[rd_ptr_reg];

  // pointers and flags kept as flops so ready never loops back
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      wr_ptr_reg  <= 1'b0;
      rd_ptr_reg  <= 1'b0;
      count_reg   <= 2'h0;
      o_in_ready  <= 1'b1;
      o_out_valid <= 1'b0;
    end else begin
      wr_ptr_reg  <= wr_ptr_reg ^ push;
      rd_ptr_reg  <= rd_ptr_reg ^ pop;
      count_reg   <= count_next;
      o_in_ready  <= (count_next != 2'h2);
      o_out_valid <= (count_next != 2'h0);
    end
  end

  // storage
  always_ff @(posedge i_clock) begin
    if (push) begin
      mem[wr_ptr_reg] <= i_in_data;
    end
  end
endmodule

// ---- design/flash_cmd_device.sv ----
// serial flash command front end: device end of the four-wire link
// assumes a 20 MHz clock well above the link clock; link pins are async
// Operation
// - modes 0 and 3 both work
// - sample on rising, drive on falling edge
// - host selects chip before any clock
// - opcode byte first, then its extra bytes
// - every byte travels most significant bit first
// - chip deselect ends the command frame
// - unknown opcode ignored until next frame
// - early deselect does nothing, back to idle
// - 24-bit address, top three bits dropped
// - both reads take address, fast adds dummy
// - block erases take address, chip erase bare
// - program takes address and 1-256 bytes; more are still passed on, count holds at 256
// - protection readback takes address, streams out
// - status write one byte, status read streams
// - id read bare, streams out until deselect
// - power down and resume are bare
// - deselect ends read and releases output
`timescale 1ns/1ps
module flash_cmd_device (
  // clock and reset
  input  wire logic   i_clock,
  input  wire logic   i_rst,
  // link
  spi_link_if.device  link,
  // command out
  output logic        o_cmd_valid,
  output logic [7:0]  o_cmd_opcode,
  output logic [20:0] o_cmd_addr,
  output logic [8:0]  o_cmd_count,
  // write data out
  output logic        o_wr_valid,
  output logic [7:0]  o_wr_data,
  // read data in
  input  wire logic [7:0] i_rd_data,
  output logic        o_rd_next
);
  import spi_cmd_pkg::*;
  `include "spi_cmd_regs.svh"

  // =====================================================================
  // opcode table
  function automatic cmd_info_t decode_op(input logic [7:0] op);
    cmd_info_t info;
    info = '0;
    case (op)
      `OP_RD_FAST:      info = '{1'b1, 1'b1, 1'b1, 1'b0, DIR_OUT};
      `OP_RD_SLOW:      info = '{1'b1, 1'b1, 1'b0, 1'b0, DIR_OUT};
      `OP_ERASE_4K,
      `OP_ERASE_32K,
      `OP_ERASE_64K:    info = '{1'b1, 1'b1, 1'b0, 1'b0, DIR_NONE};
      `OP_CHIP_ERASE_A,
      `OP_CHIP_ERASE_B: info = '{1'b1, 1'b0, 1'b0, 1'b0, DIR_NONE};
      `OP_PROGRAM:      info = '{1'b1, 1'b1, 1'b0, 1'b0, DIR_IN};
      `OP_RD_PROT:      info = '{1'b1, 1'b1, 1'b0, 1'b0, DIR_OUT};
      `OP_WR_STATUS:    info = '{1'b1, 1'b0, 1'b0, 1'b1, DIR_IN};
      `OP_RD_STATUS:    info = '{1'b1, 1'b0, 1'b0, 1'b0, DIR_OUT};
      `OP_RD_ID:        info = '{1'b1, 1'b0, 1'b0, 1'b0, DIR_OUT};
      `OP_PWR_DOWN,
      `OP_PWR_RESUME:   info = '{1'b1, 1'b0, 1'b0, 1'b0, DIR_NONE};
      `OP_WR_EN,
      `OP_WR_DIS:       info = '{1'b1, 1'b0, 1'b0, 1'b0, DIR_NONE};
      `OP_PROT,
      `OP_UNPROT:       info = '{1'b1, 1'b1, 1'b0, 1'b0, DIR_NONE};
      default:          info = '0;
    endcase
    return info;
  endfunction

  // phase that follows the opcode or address bytes
  function automatic dev_state_t next_phase(input cmd_info_t info);
    dev_state_t st;
    st = ST_HOLD;
    if (!info.known) begin
      st = ST_IGNR;
    end else if (info.has_dummy) begin
      st = ST_DUMMY;
    end else if (info.dir == DIR_OUT) begin
      st = ST_DOUT;
    end else if (info.dir == DIR_IN) begin
      st = ST_DIN;
    end
    return st;
  endfunction

  // =====================================================================
  // pin synchronisers
  logic cs_s1_reg, cs_s2_reg, cs_d_reg;
  logic sck_s1_reg, sck_s2_reg, sck_d_reg;
  logic mosi_s1_reg, mosi_s2_reg;

  // two sync flops per pin plus an edge flop on cs and sck; sck and data share depth so they stay aligned
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      cs_s1_reg   <= 1'b1;
      cs_s2_reg   <= 1'b1;
      cs_d_reg    <= 1'b1;
      sck_s1_reg  <= 1'b0;
      sck_s2_reg  <= 1'b0;
      sck_d_reg   <= 1'b0;
      mosi_s1_reg <= 1'b0;
      mosi_s2_reg <= 1'b0;
    end else begin
      cs_s1_reg   <= link.cs_n;
      cs_s2_reg   <= cs_s1_reg;
      cs_d_reg    <= cs_s2_reg;
      sck_s1_reg  <= link.sck;
      sck_s2_reg  <= sck_s1_reg;
      sck_d_reg   <= sck_s2_reg;
      mosi_s1_reg <= link.mosi;
      mosi_s2_reg <= mosi_s1_reg;
    end
  end

  // =====================================================================
  // edges and decode
  dev_state_t state_reg, state_next;
  cmd_info_t  info_reg;
  cmd_info_t  op_info;
  logic [2:0] bit_cnt_reg;
  logic [1:0] byte_cnt_reg;
  logic [7:0] shift_reg;
  logic [7:0] out_reg;
  logic [7:0] byte_in;
  logic       sck_rise;
  logic       sck_fall;
  logic       cs_rise;
  logic       byte_done;
  logic       frame_ok;
  logic       read_start;
  logic       out_load;

  // edges only count inside a frame; idle level of sck is irrelevant
  assign sck_rise   = sck_s2_reg & ~sck_d_reg & ~cs_s2_reg;
  assign sck_fall   = ~sck_s2_reg & sck_d_reg & ~cs_s2_reg;
  assign cs_rise    = cs_s2_reg & ~cs_d_reg;
  assign byte_in    = {shift_reg[6:0], mosi_s2_reg};
  assign byte_done  = sck_rise & (bit_cnt_reg == `LAST_BIT);
  assign op_info    = decode_op(byte_in);
  assign read_start = (state_next == ST_DOUT) & (state_reg != ST_DOUT);
  assign out_load   = sck_fall & (state_reg == ST_DOUT) & (bit_cnt_reg == 3'h0);
  // a frame counts only if every byte it needs arrived whole
  assign frame_ok   = (state_reg == ST_HOLD)
                    | ((state_reg == ST_DIN) & (o_cmd_count != 9'h000)
                       & (bit_cnt_reg == 3'h0));

  // =====================================================================
  // frame sequencing
  always_comb begin
    state_next = state_reg;
    if (cs_s2_reg) begin
      state_next = ST_IDLE;
    end else if (state_reg == ST_IDLE) begin
      state_next = ST_OPC;
    end else if (byte_done) begin
      case (state_reg)
        ST_OPC: begin
          state_next = op_info.has_addr ? ST_ADDR : next_phase(op_info);
        end
        ST_ADDR: begin
          if (byte_cnt_reg == `LAST_ADDR_BYTE) begin
            state_next = next_phase(info_reg);
          end
        end
        ST_DUMMY: state_next = ST_DOUT;
        ST_DIN: begin
          if (info_reg.one_byte) begin
            state_next = ST_HOLD;
          end
        end
        default: state_next = state_reg;
      endcase
    end
  end

  // state and bit position
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      state_reg    <= ST_IDLE;
      bit_cnt_reg  <= 3'h0;
      byte_cnt_reg <= 2'h0;
      shift_reg    <= 8'h00;
    end else begin
      state_reg    <= state_next;
      bit_cnt_reg  <= cs_s2_reg ? 3'h0 : bit_cnt_reg + {2'h0, sck_rise};
      if (cs_s2_reg) begin
        byte_cnt_reg <= 2'h0;
      end else if (byte_done && state_reg == ST_ADDR) begin
        byte_cnt_reg <= byte_cnt_reg + 2'h1;
      end
      if (sck_rise) begin
        shift_reg <= byte_in;
      end
    end
  end

  // =====================================================================
  // captured command fields
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      info_reg     <= '0;
      o_cmd_opcode <= 8'h00;
      o_cmd_addr   <= 21'h000000;
      o_cmd_count  <= 9'h000;
    end else begin
      if (state_reg == ST_OPC && byte_done) begin
        info_reg     <= op_info;
        o_cmd_opcode <= byte_in;
      end
      // shifting 24 bits through 21 drops the top three
      if (state_reg == ST_ADDR && sck_rise) begin
        o_cmd_addr <= {o_cmd_addr[19:0], mosi_s2_reg};
      end
      // cleared at frame start so the count survives the end pulse
      if (state_reg == ST_IDLE && !cs_s2_reg) begin
        o_cmd_count <= 9'h000;
      end else if (state_reg == ST_DIN && byte_done && o_cmd_count != `PAGE_BYTES) begin
        o_cmd_count <= o_cmd_count + 9'h001;
      end
    end
  end

  // =====================================================================
  // user-side pulses
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_cmd_valid <= 1'b0;
      o_wr_valid  <= 1'b0;
      o_wr_data   <= 8'h00;
      o_rd_next   <= 1'b0;
    end else begin
      o_cmd_valid <= (cs_rise & frame_ok) | read_start;
      o_wr_valid  <= byte_done & (state_reg == ST_DIN);
      if (byte_done && state_reg == ST_DIN) begin
        o_wr_data <= byte_in;
      end
      o_rd_next   <= out_load;
    end
  end

  // =====================================================================
  // serial output, moved only on falling edges
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      out_reg      <= 8'h00;
      link.miso    <= 1'b0;
      link.miso_oe <= 1'b0;
    end else if (cs_s2_reg) begin
      link.miso_oe <= 1'b0;
    end else if (sck_fall && state_reg == ST_DOUT) begin
      link.miso_oe <= 1'b1;
      if (out_load) begin
        link.miso <= i_rd_data[7];
        out_reg   <= {i_rd_data[6:0], 1'b0};
      end else begin
        link.miso <= out_reg[7];
        out_reg   <= {out_reg[6:0], 1'b0};
      end
    end
  end
endmodule

// ---- design/spi_host_master.sv ----
// host end of the four-wire flash link: frames bytes from a buffer
// assumes the user queues bytes with a last flag that closes the frame
`timescale 1ns/1ps
module spi_host_master (
  // clock and reset
  input  wire logic  i_clock,
  input  wire logic  i_rst,
  // link
  spi_link_if.host   link,
  // mode: high keeps sck idle high
  input  wire logic  i_mode3,
  // bytes to send
  input  wire logic       i_tx_valid,
  input  wire logic [7:0] i_tx_data,
  input  wire logic       i_tx_last,
  output logic       o_tx_ready,
  // bytes received
  output logic       o_rx_valid,
  output logic [7:0] o_rx_data,
  output logic       o_busy
);
  import spi_cmd_pkg::*;
  `include "spi_cmd_regs.svh"

  localparam logic [3:0] HALF_LAST = 4'(`SCK_HALF_CYCLES - 1);

  // =====================================================================
  // byte queue; the shifter only drains between bytes
  logic       buf_valid;
  logic       buf_ready;
  logic [8:0] buf_data;

  fifo2 #(.WIDTH(9)) u_queue (
    .i_clock     (i_clock),
    .i_rst       (i_rst),
    .i_in_valid  (i_tx_valid),
    .o_in_ready  (o_tx_ready),
    .i_in_data   ({i_tx_last, i_tx_data}),
    .o_out_valid (buf_valid),
    .i_out_ready (buf_ready),
    .o_out_data  (buf_data)
  );

  // =====================================================================
  // state and decode
  host_state_t state_reg, state_next;
  logic [3:0]  half_reg;
  logic [2:0]  bit_reg;
  logic [7:0]  sh_reg;
  logic [7:0]  rx_reg;
  logic        last_reg;
  logic        miso_s1_reg, miso_s2_reg;
  logic        half_tick;
  logic        byte_end;
  logic        go_low;

  assign half_tick = (half_reg == HALF_LAST);
  assign byte_end  = (state_reg == H_HIGH) & half_tick & (bit_reg == `LAST_BIT);
  // an empty queue mid-frame stretches sck instead of losing a byte
  assign buf_ready = buf_valid & (((state_reg == H_SEL) & half_tick)
                   | (state_reg == H_WAIT) | (byte_end & ~last_reg));
  assign go_low    = buf_ready | ((state_reg == H_HIGH) & half_tick & ~byte_end);

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      H_IDLE:  if (buf_valid) state_next = H_SEL;
      H_SEL:   if (go_low) state_next = H_LOW;
      H_LOW:   if (half_tick) state_next = H_HIGH;
      H_HIGH: begin
        if (go_low) begin
          state_next = H_LOW;
        end else if (byte_end) begin
          state_next = last_reg ? H_END : H_WAIT;
        end
      end
      H_WAIT:  if (go_low) state_next = H_LOW;
      H_END:   if (half_tick) state_next = H_DESEL;
      H_DESEL: if (half_tick) state_next = H_IDLE;
      default: state_next = H_IDLE;
    endcase
  end

  // =====================================================================
  // sequencing and pins
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      state_reg <= H_IDLE;
      half_reg  <= 4'h0;
      bit_reg   <= 3'h0;
      link.cs_n <= 1'b1;
      link.sck  <= 1'b0;
      link.mosi <= 1'b0;
      o_busy    <= 1'b0;
    end else begin
      state_reg <= state_next;
      half_reg  <= (state_next != state_reg) ? 4'h0 : half_reg + 4'h1;
      link.cs_n <= (state_next == H_IDLE) | (state_next == H_DESEL);
      o_busy    <= (state_next != H_IDLE);
      if (buf_ready) begin
        bit_reg <= 3'h0;
      end else if (go_low) begin
        bit_reg <= bit_reg + 3'h1;
      end
      // mosi changes only with sck low, ahead of the rising edge
      if (go_low) begin
        link.sck  <= 1'b0;
        link.mosi <= buf_ready ? buf_data[7] : sh_reg[6];
      end else if (state_reg == H_LOW && half_tick) begin
        link.sck <= 1'b1;
      end else if (state_reg == H_IDLE || state_next == H_END) begin
        link.sck <= i_mode3;
      end
    end
  end

  // =====================================================================
  // shifters; miso read late in the high phase, after both sync flops
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      sh_reg      <= 8'h00;
      rx_reg      <= 8'h00;
      last_reg    <= 1'b0;
      miso_s1_reg <= 1'b1;
      miso_s2_reg <= 1'b1;
      o_rx_valid  <= 1'b0;
      o_rx_data   <= 8'h00;
    end else begin
      miso_s1_reg <= link.miso_line;
      miso_s2_reg <= miso_s1_reg;
      if (buf_ready) begin
        sh_reg   <= buf_data[7:0];
        last_reg <= buf_data[8];
      end else if (go_low) begin
        sh_reg <= {sh_reg[6:0], 1'b0};
      end
      if (state_reg == H_HIGH && half_tick) begin
        rx_reg <= {rx_reg[6:0], miso_s2_reg};
      end
      o_rx_valid <= byte_end;
      if (byte_end) begin
        o_rx_data <= {rx_reg[6:0], miso_s2_reg};
      end
    end
  end
endmodule

// ---- tb/flash_link_asserts.sv ----
// link checker for the serial flash command front end
// assumes it sits beside the link interface and watches its wires
`timescale 1ns/1ps
module flash_link_asserts (
  // clock and reset
  input  wire logic i_clock,
  input  wire logic i_rst,
  // link wires
  input  wire logic cs_n,
  input  wire logic sck,
  input  wire logic miso,
  input  wire logic miso_oe
);
  // ==================================================================
  // helper counters on the raw link clock
  logic       sck_q_reg;
  logic [3:0] fall_age_reg;
  logic [3:0] fall_age_next;
  logic [5:0] rise_cnt_reg;
  logic [5:0] rise_cnt_next;
  wire        sck_fell = sck_q_reg & ~sck;
  wire        sck_rose = ~sck_q_reg & sck;
  // both saturate so a long idle never wraps into a false match
  assign fall_age_next = sck_fell ? 4'h0 : (fall_age_reg == 4'hF) ? 4'hF : fall_age_reg + 4'h1;
  assign rise_cnt_next = cs_n ? 6'h00 :
                         (sck_rose && rise_cnt_reg != 6'h3F) ? rise_cnt_reg + 6'h01 : rise_cnt_reg;

  // edge history and counts
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      sck_q_reg    <= 1'b0;
      fall_age_reg <= 4'hF;
      rise_cnt_reg <= 6'h00;
    end else begin
      sck_q_reg    <= sck;
      fall_age_reg <= fall_age_next;
      rise_cnt_reg <= rise_cnt_next;
    end
  end

  // ==================================================================
  // assertions, one clock domain
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_rst);

  chk_oe_only_selected: assert property ($rose(miso_oe) |-> !cs_n)
    else $error("data out driven while chip not selected");
  chk_oe_after_opcode: assert property ($rose(miso_oe) |-> rise_cnt_reg >= 6'h08)
    else $error("data out driven before a whole opcode arrived");
  chk_oe_follows_fall: assert property ($rose(miso_oe) |-> fall_age_reg <= 4'h6)
    else $error("data out enabled away from a falling clock edge");
  chk_miso_on_fall: assert property ($changed(miso) && miso_oe && $past(miso_oe)
    |-> fall_age_reg <= 4'h6)
    else $error("data out changed away from a falling clock edge");
  chk_release_on_desel: assert property ($rose(cs_n) |-> ##[1:5] !miso_oe)
    else $error("data out not released after deselect");
  chk_idle_released: assert property (cs_n [*6] |-> !miso_oe)
    else $error("data out driven between frames");
  chk_sel_before_clock: assert property ($rose(sck) && !cs_n |-> $past(cs_n, 8) == 1'b0)
    else $error("link clock rose too soon after select");
  chk_half_period: assert property ($changed(sck) && !cs_n |=> $stable(sck) [*3])
    else $error("link clock half period too short");

  // main scenarios reached
  cover property ($rose(miso_oe));
  cover property ($rose(cs_n) && sck);
  cover property (rise_cnt_reg == 6'h3F);
endmodule

// ---- tb/tb_top.sv ----
// self-checking bench: host and device ends joined over the link
// assumes the package, interface and both ends compile first
`timescale 1ns/1ps
module tb_top;
  import spi_cmd_pkg::*;
  // ==================================================================
  // stimulus and observed signals
  logic        i_clock  = 1'b0;
  logic        i_rst    = 1'b1;
  logic        mode3    = 1'b0;
  logic        tx_valid = 1'b0;
  logic [7:0]  tx_data  = 8'h00;
  logic        tx_last  = 1'b0;
  logic [7:0]  rd_data  = 8'h5A;
  logic        cmd_valid, wr_valid, rd_next, tx_ready, rx_valid, busy;
  logic [7:0]  cmd_opcode, wr_data, rx_data;
  logic [20:0] cmd_addr;
  logic [8:0]  cmd_count;
  int          err_total  = 0;
  int          num_checks = 0;
  int          cmd_seen   = 0;
  logic [7:0]  seen_op;
  logic [20:0] seen_addr;
  logic [8:0]  seen_count;
  logic [7:0]  wr_q[$];
  logic [7:0]  rx_q[$];
  // opcode, header bytes after it, data bytes, read flag
  logic [19:0] op_tbl[18] = '{20'h0B421, 20'h03321, 20'h20300, 20'h52300, 20'hD8300,
    20'h60000, 20'hC7000, 20'h02330, 20'h06000, 20'h04000, 20'h36300, 20'h39300,
    20'h3C321, 20'h05021, 20'h01010, 20'h9F041, 20'hB9000, 20'hAB000};

  // ==================================================================
  // both ends face each other over one link
  spi_link_if spi_link_if_i ();
  flash_cmd_device flash_cmd_device_i (.i_clock(i_clock), .i_rst(i_rst),
    .link(spi_link_if_i.device), .o_cmd_valid(cmd_valid), .o_cmd_opcode(cmd_opcode),
    .o_cmd_addr(cmd_addr), .o_cmd_count(cmd_count), .o_wr_valid(wr_valid),
    .o_wr_data(wr_data), .i_rd_data(rd_data), .o_rd_next(rd_next));
  spi_host_master spi_host_master_i (.i_clock(i_clock), .i_rst(i_rst),
    .link(spi_link_if_i.host), .i_mode3(mode3), .i_tx_valid(tx_valid), .i_tx_data(tx_data),
    .i_tx_last(tx_last), .o_tx_ready(tx_ready), .o_rx_valid(rx_valid), .o_rx_data(rx_data),
    .o_busy(busy));
  flash_link_asserts flash_link_asserts_i (.i_clock(i_clock), .i_rst(i_rst),
    .cs_n(spi_link_if_i.cs_n), .sck(spi_link_if_i.sck), .miso(spi_link_if_i.miso),
    .miso_oe(spi_link_if_i.miso_oe));

  // ==================================================================
  // clock, read data source, monitors
  initial begin
    forever #25 i_clock = ~i_clock;
  end

  // read data steps per consumed byte and restarts between frames
  always @(posedge i_clock) begin
    rd_data <= (busy !== 1'b1) ? 8'h5A : (rd_next === 1'b1) ? rd_data + 8'h11 : rd_data;
  end

  // capture what each end reports
  always @(posedge i_clock) begin
    if (cmd_valid === 1'b1) begin
      cmd_seen++;
      seen_op    = cmd_opcode;
      seen_addr  = cmd_addr;
      seen_count = cmd_count;
    end
    if (wr_valid === 1'b1) wr_q.push_back(wr_data);
    if (rx_valid === 1'b1) rx_q.push_back(rx_data);
  end

  // ==================================================================
  // tasks
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // one byte into the host queue; valid stays up between bytes
  task automatic push(input logic [7:0] d, input logic l);
    tx_valid <= 1'b1;
    tx_data  <= d;
    tx_last  <= l;
    @(posedge i_clock);
    while (tx_ready !== 1'b1) @(posedge i_clock);
  endtask

  // one whole frame; address carries set top bits that must be dropped
  task automatic run(input logic [7:0] op, input int nhdr, input int ndata, input logic rd,
                     input logic ok, input logic m3);
    logic [7:0] b[$];
    logic [7:0] e;
    mode3 <= m3;
    cmd_seen = 0;
    wr_q = {};
    rx_q = {};
    b = {op, 8'hE1, 8'h23, 8'h45, 8'h00};
    b = b[0:nhdr];
    for (int k = 0; k < ndata; k++) b.push_back(rd ? 8'h00 : 8'hC0 + k[7:0]);
    repeat (2) @(posedge i_clock);
    for (int k = 0; k < b.size(); k++) push(b[k], k == b.size() - 1);
    tx_valid <= 1'b0;
    repeat (4) @(posedge i_clock);
    while (busy === 1'b1) @(posedge i_clock);
    repeat (4) @(posedge i_clock);
    check("command count", cmd_seen, {31'h0, ok});
    check("write bytes", wr_q.size(), (ok && !rd) ? ndata : 0);
    check("bytes read", rx_q.size(), b.size());
    if (ok) begin
      check("opcode", seen_op, op);
      if (nhdr >= 3) check("address", seen_addr, 21'h012345);
      if (!rd && ndata > 0) check("data count", seen_count, (ndata > 256) ? 256 : ndata);
    end
    for (int k = 0; k < rx_q.size(); k++) begin
      e = (ok && rd && k > nhdr) ? 8'h5A + 8'h11 * (k - nhdr - 1) : 8'hFF;
      check("read byte", rx_q[k], e);
    end
    for (int k = 0; k < wr_q.size(); k++) begin
      e = 8'hC0 + k;
      check("write byte", wr_q[k], e);
    end
  endtask

  // ==================================================================
  // main sequence: every opcode in both modes, then three refusals and an overlong program
  initial begin
    repeat (5) @(posedge i_clock);
    i_rst <= 1'b0;
    for (int m = 0; m < 2; m++)
      for (int t = 0; t < 18; t++)
        run(op_tbl[t][19:12], op_tbl[t][11:8], op_tbl[t][7:4], op_tbl[t][0], 1'b1, m[0]);
    run(8'h77, 3, 0, 1'b0, 1'b0, 1'b0);
    run(8'h20, 2, 0, 1'b0, 1'b0, 1'b1);
    run(8'h02, 3, 0, 1'b0, 1'b0, 1'b0);
    run(8'h02, 3, 257, 1'b0, 1'b1, 1'b1);
    report_and_stop();
  end

  // tests take about 52k cycles; a hang is cut off before 100k
  initial begin
    repeat (95000) @(posedge i_clock);
    err_total++;
    report_and_stop();
  end
endmodule
